// ===== rtl/rsp_pkg.sv
// package: array sizes, reset values and preload levels for the logic array
package rsp_pkg;
   // ---------------------------------------------------------------
   // array dimensions
   // ---------------------------------------------------------------
   localparam int N_IN       = 20;
   localparam int N_OUT      = 8;
   localparam int N_TERM     = 8;
   localparam int N_REG_DEF  = 6;
   // ---------------------------------------------------------------
   // reset and preload levels
   // ---------------------------------------------------------------
   localparam logic REG_RST_VAL   = 1'h0;
   localparam logic PRELOAD_SET   = 1'h0;
   // ---------------------------------------------------------------
   // verify port state machine
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RSP_RUN     = 2'b00,
      RSP_PRELOAD = 2'b01,
      RSP_LOCKED  = 2'b10
   } rsp_mode_t;
endpackage

// ===== rtl/rsp_term.sv
// one product term of the and plane
`timescale 1ns/1ps
module rsp_term #(
   parameter int W = 28
) (
   // literal inputs: true and inverted forms
   input  wire logic [W-1:0] lit_t_i,
   input  wire logic [W-1:0] lit_c_i,
   // fuse map: 1 means the link is intact
   input  wire logic [W-1:0] use_t_i,
   input  wire logic [W-1:0] use_c_i,
   // product out
   output logic              prod_o
);
   // -----------------------------------------------------------------
   // product
   // -----------------------------------------------------------------
   // all links removed gives an empty and, i.e. high a term
   // holding both forms of one input always meets a zero
   always_comb begin
      prod_o = &((lit_t_i | ~use_t_i) & (lit_c_i | ~use_c_i));
   end
endmodule

// ===== rtl/rsp_array.sv
// registered sum-of-products logic array with preload and read-back lock
`timescale 1ns/1ps
module rsp_array #(
   parameter int N_REG = rsp_pkg::N_REG_DEF
) (
   // clock and power-up reset
   input  wire logic                     clk_i,
   input  wire logic                     nrst_i,
   // array input pins
   input  wire logic [rsp_pkg::N_IN-1:0] in_i,
   // output enable pin for registered outputs, active low
   input  wire logic                     reg_oe_n_i,
   // output pins as three signals
   input  wire logic [rsp_pkg::N_OUT-1:0] pin_i,
   output logic [rsp_pkg::N_OUT-1:0]      pin_o,
   output logic [rsp_pkg::N_OUT-1:0]      pin_oe_o,
   // test: preload strobe and fuse pattern
   input  wire logic                     preload_i,
   input  wire logic [rsp_pkg::N_OUT*rsp_pkg::N_TERM*56-1:0] fuse_i,
   input  wire logic [rsp_pkg::N_OUT-1:0] pol_high_i,
   input  wire logic [rsp_pkg::N_OUT*56-1:0] oe_fuse_i,
   input  wire logic [1:0]               sec_fuse_i,
   // verify port: read a fuse word
   input  wire logic [5:0]               rd_idx_i,
   output logic [55:0]                   rd_data_o,
   output logic                          rd_ok_o
);
   localparam int NI = rsp_pkg::N_IN;
   localparam int NO = rsp_pkg::N_OUT;
   localparam int NT = rsp_pkg::N_TERM;
   localparam int W  = NI + NO;   // literals: inputs plus feedback
   localparam int FW = 2 * W;     // link bits per term

   // -----------------------------------------------------------------
   // parameter check
   // -----------------------------------------------------------------
   if (!(N_REG == 0 || N_REG == 4 || N_REG == 6 || N_REG == 8)) begin : g_bad
      $error("N_REG must be 0, 4, 6 or 8");
   end
   if (FW != 56) begin : g_bad_w
      $error("fuse word width must match 2*(inputs+outputs)");
   end

   // registered outputs occupy the middle pins
   localparam int R_LO = (NO - N_REG) / 2;
   localparam int R_HI = R_LO + N_REG;

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   // fuse and polarity maps are static configuration and are read directly;
   // live pins and the security fuses pay the two-flop latency
   logic [NI-1:0] in_s1_q, in_s2_q;
   logic [NO-1:0] pin_s1_q, pin_s2_q;
   logic          oe_s1_q, oe_s2_q, pl_s1_q, pl_s2_q, pl_s3_q;
   logic [1:0]    sec_s1_q, sec_s2_q;
   always_ff @(posedge clk_i) begin
      in_s1_q  <= in_i;
      in_s2_q  <= in_s1_q;
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      oe_s1_q  <= reg_oe_n_i;
      oe_s2_q  <= oe_s1_q;
      pl_s1_q  <= preload_i;
      pl_s2_q  <= pl_s1_q;
      pl_s3_q  <= pl_s2_q;
      sec_s1_q <= sec_fuse_i;
      sec_s2_q <= sec_s1_q;
   end

   // -----------------------------------------------------------------
   // and plane and or plane
   // -----------------------------------------------------------------
   logic [NO-1:0]    st_q, st_d;
   logic [W-1:0]     lit;
   logic [NO*NT-1:0] prod;
   logic [NO-1:0]    sop, oe_term;

   // pins of combinational outputs feed back too; registers feed state
   always_comb begin
      lit = {pin_s2_q, in_s2_q};
      for (int k = R_LO; k < R_HI; k++) begin
         lit[NI+k] = st_q[k];
      end
   end

   for (genvar g = 0; g < NO*NT; g++) begin : g_term
      rsp_term #(.W(W)) u_term (
         .lit_t_i (lit),
         .lit_c_i (~lit),
         .use_t_i (fuse_i[g*FW +: W]),
         .use_c_i (fuse_i[g*FW+W +: W]),
         .prod_o  (prod[g])
      );
   end

   for (genvar o = 0; o < NO; o++) begin : g_out
      assign sop[o] = |prod[o*NT +: NT];
      rsp_term #(.W(W)) u_oe (
         .lit_t_i (lit),
         .lit_c_i (~lit),
         .use_t_i (oe_fuse_i[o*FW +: W]),
         .use_c_i (oe_fuse_i[o*FW+W +: W]),
         .prod_o  (oe_term[o])
      );
   end

   // -----------------------------------------------------------------
   // registers: capture, preload and power-up clear
   // -----------------------------------------------------------------
   // preload is taken on the synchronised strobe's rising edge; the
   // pins must be released by the driver (reg oe high) at that time
   // a strobe held high acts once, so a slow tester cannot reload twice
   always_comb begin
      st_d = st_q;
      for (int k = R_LO; k < R_HI; k++) begin
         if (pl_s2_q && !pl_s3_q && oe_s2_q) begin
            st_d[k] = (pin_s2_q[k] == rsp_pkg::PRELOAD_SET);
         end else begin
            st_d[k] = sop[k];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_q <= {NO{rsp_pkg::REG_RST_VAL}};
      end else begin
         st_q <= st_d;
      end
   end

   // -----------------------------------------------------------------
   // output drivers
   // -----------------------------------------------------------------
   // a registered pin shows the inverted flop, so a cleared register
   // reads high whatever the polarity link says
   logic [NO-1:0] pin_d, oe_d, pin_q, oe_q;
   always_comb begin
      for (int k = 0; k < NO; k++) begin
         if (k >= R_LO && k < R_HI) begin
            pin_d[k] = ~st_q[k];
            oe_d[k]  = ~oe_s2_q;
         end else begin
            pin_d[k] = sop[k] ~^ pol_high_i[k];
            oe_d[k]  = oe_term[k];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pin_q <= '1;
         oe_q  <= '0;
      end else begin
         pin_q <= pin_d;
         oe_q  <= oe_d;
      end
   end
   assign pin_o    = pin_q;
   assign pin_oe_o = oe_q;

   // -----------------------------------------------------------------
   // verify port with security lock
   // -----------------------------------------------------------------
   // the index is taken directly so a word answers one edge later; a
   // changing index simply shows the newer word
   rsp_pkg::rsp_mode_t mode_q, mode_d;
   logic [55:0]        rd_q, rd_d;
   logic               ok_q, ok_d;

   always_comb begin
      mode_d = mode_q;
      rd_d   = '0;
      ok_d   = 1'h0;
      unique case (mode_q)
         rsp_pkg::RSP_RUN,
         rsp_pkg::RSP_PRELOAD: begin
            mode_d = pl_s2_q ? rsp_pkg::RSP_PRELOAD : rsp_pkg::RSP_RUN;
            if (&sec_s2_q) begin
               mode_d = rsp_pkg::RSP_LOCKED;
            end else if (int'(rd_idx_i) < NO*NT) begin
               rd_d = fuse_i[int'(rd_idx_i)*FW +: FW];
               ok_d = 1'h1;
            end
         end
         // lock holds until reset: dropping the fuse inputs never heals it
         rsp_pkg::RSP_LOCKED: begin
            mode_d = rsp_pkg::RSP_LOCKED;
         end
         default: begin
            mode_d = rsp_pkg::RSP_LOCKED;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mode_q <= rsp_pkg::RSP_RUN;
         rd_q   <= '0;
         ok_q   <= 1'h0;
      end else begin
         mode_q <= mode_d;
         rd_q   <= rd_d;
         ok_q   <= ok_d;
      end
   end
   assign rd_data_o = rd_q;
   assign rd_ok_o   = ok_q;
endmodule

// ===== tb/rsp_array_properties.sv
// checker: port-level properties of the logic array
`timescale 1ns/1ps
module rsp_array_properties #(
   parameter int N_REG = 6
) (
   // clock, reset and inputs
   input wire logic          clk_i,
   input wire logic          nrst_i,
   input wire logic          reg_oe_n_i,
   input wire logic          preload_i,
   input wire logic [3583:0] fuse_i,
   input wire logic [7:0]    pol_high_i,
   input wire logic [447:0]  oe_fuse_i,
   input wire logic [1:0]    sec_fuse_i,
   input wire logic [5:0]    rd_idx_i,
   // outputs
   input wire logic [7:0]    pin_o,
   input wire logic [7:0]    pin_oe_o,
   input wire logic [55:0]   rd_data_o,
   input wire logic          rd_ok_o
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   localparam logic [7:0] RM = 8'(((1 << N_REG) - 1) << ((8 - N_REG) / 2));
   logic lock_q;
   // sticky: a lock stays until reset even if the fuse inputs drop
   always_ff @(posedge clk_i) lock_q <= nrst_i && (lock_q || &sec_fuse_i);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_rst_outputs: assert property ($rose(nrst_i) |->
      pin_o == 8'hff && pin_oe_o == 8'h00 && !rd_ok_o) else $error("reset");
   a_read_answer: assert property ((!lock_q && !(&sec_fuse_i)) [*4] |=>
      rd_ok_o && rd_data_o == $past(fuse_i[rd_idx_i*56 +: 56]))
      else $error("read");
   a_lock_refuse: assert property ((&sec_fuse_i) [*4] |=>
      !rd_ok_o && rd_data_o == 56'h0) else $error("lock");
   a_lock_sticky: assert property ($fell(rd_ok_o) |->
      (!rd_ok_o && rd_data_o == 56'h0) [*8]) else $error("sticky");
   a_reg_oe_off: assert property (reg_oe_n_i [*4] |->
      (pin_oe_o & RM) == 8'h00) else $error("oe off");
   a_reg_oe_on: assert property (!reg_oe_n_i [*4] |->
      (pin_oe_o & RM) == RM) else $error("oe on");
   a_comb_oe_term: assert property ((oe_fuse_i == '0) [*4] |->
      (pin_oe_o & ~RM) == ~RM) else $error("comb oe");
   a_comb_pol_sel: assert property
      ((fuse_i[447:0] == '0 && $stable(pol_high_i)) [*5] |->
      pin_o[0] == pol_high_i[0]) else $error("polarity");
   c_preload: cover property ($rose(preload_i) && reg_oe_n_i);
   c_lock: cover property ($fell(rd_ok_o));
   c_read: cover property (rd_ok_o);
endmodule

// ===== tb/rsp_board.sv
// partner model: board logic resolving the output pin levels
`timescale 1ns/1ps
module rsp_board (
   // device side of the pins
   input  wire logic [7:0] dev_val_i,
   input  wire logic [7:0] dev_oe_i,
   // board drive, only honoured on released pins
   input  wire logic [7:0] en_i,
   input  wire logic [7:0] val_i,
   // resolved level
   output logic [7:0]      lvl_o
);
   // released and undriven pins rest on the board pull-ups
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         if (dev_oe_i[k]) lvl_o[k] = dev_val_i[k];
         else if (en_i[k]) lvl_o[k] = val_i[k];
         else lvl_o[k] = 1'h1;
      end
   end
endmodule

// ===== tb/tb.sv
// testbench: self-checking run of the logic array
`timescale 1ns/1ps
module tb;
   logic          clk_i, nrst_i, reg_oe_n_i, preload_i, rd_ok_o;
   logic [19:0]   in_i;
   logic [3583:0] fuse_i;
   logic [447:0]  oe_fuse_i;
   logic [7:0]    pin_i, pin_o, pin_oe_o, pol_high_i, drv_en, drv_val;
   logic [1:0]    sec_fuse_i;
   logic [5:0]    rd_idx_i;
   logic [55:0]   rd_data_o;
   int            err_count, samples_checked;
   rsp_array #(.N_REG(6)) dut_u (.clk_i, .nrst_i, .in_i, .reg_oe_n_i, .pin_i,
      .pin_o, .pin_oe_o, .preload_i, .fuse_i, .pol_high_i, .oe_fuse_i,
      .sec_fuse_i, .rd_idx_i, .rd_data_o, .rd_ok_o);
   rsp_board brd_u (.dev_val_i(pin_o), .dev_oe_i(pin_oe_o), .en_i(drv_en),
      .val_i(drv_val), .lvl_o(pin_i));
   always #2 clk_i = ~clk_i;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic term(input int g, input logic [27:0] t,
                       input logic [27:0] c);
      fuse_i[g*56 +: 56] = {c, t};
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // registered outputs hold their own state through feedback; set up
   // before release so the cleared state survives the first edges
   task automatic t_reset;
      for (int o = 1; o < 7; o++) begin
         term(o * 8, 28'h1 << (20 + o), 28'h0);
         for (int k = 1; k < 8; k++) term(o * 8 + k, 28'h1, 28'h1);
      end
      tick(10);
      check({pin_o, pin_oe_o, rd_ok_o}, 17'h1fe00);
      nrst_i = 1'h1;
      tick(5);
      check(pin_o[0], 1'h0);
   endtask
   task automatic t_comb;
      pol_high_i = 8'hff;
      tick(5);
      check({pin_o[0], pin_oe_o[0]}, 2'h3);
      for (int g = 0; g < 8; g++) term(g, 28'h1, 28'h1);
      tick(5);
      check(pin_o[0], 1'h0);
      term(0, 28'h80000, 28'h0);
      in_i[19] = 1'h1;
      tick(5);
      check(pin_o[0], 1'h1);
      check({pin_o[6:1], pin_oe_o[6:1]}, 12'hfff);
   endtask
   task automatic t_preload(input logic [5:0] pat);
      reg_oe_n_i = 1'h1;
      drv_en = 8'h7e;
      drv_val = {1'h0, pat, 1'h0};
      tick(5);
      check(pin_oe_o[6:1], 6'h0);
      preload_i = 1'h1;
      tick(2);
      preload_i = 1'h0;
      tick(4);
      {drv_en, reg_oe_n_i} = '0;
      tick(5);
      check(pin_o[6:1], pat);
   endtask
   task automatic t_capture;
      term(8, 28'h20, 28'h0);
      in_i[5] = 1'h1;
      tick(6);
      in_i[5] = 1'h0;
      tick(3);
      check(pin_o[1], 1'h0);
      tick(1);
      check(pin_o[1], 1'h1);
   endtask
   task automatic t_readback;
      rd_idx_i = 6'h09;
      sec_fuse_i = 2'h1;
      tick(4);
      check({rd_ok_o, rd_data_o}, 57'h100000010000001);
      sec_fuse_i = 2'h3;
      tick(4);
      check({rd_ok_o, rd_data_o}, 57'h0);
      {rd_idx_i, sec_fuse_i} = '0;
      tick(4);
      check({rd_ok_o, rd_data_o}, 57'h0);
   endtask
   // a mid-run reset clears the registers and heals the read-back lock
   task automatic t_rerun;
      nrst_i = 1'h0;
      tick(3);
      check({pin_o, pin_oe_o, rd_ok_o}, 17'h1fe00);
      nrst_i = 1'h1;
      tick(5);
      check(pin_o, 8'hff);
      check({rd_ok_o, rd_data_o}, 57'h100000000080000);
   endtask
   task automatic final_report;
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {clk_i, nrst_i, reg_oe_n_i, preload_i, in_i, fuse_i, oe_fuse_i} = '0;
      {drv_en, drv_val, sec_fuse_i, rd_idx_i, err_count, samples_checked} = '0;
      pol_high_i = 8'hfe;
      t_reset;
      t_comb;
      t_preload(6'h15);
      t_preload(6'h2a);
      t_capture;
      t_readback;
      t_rerun;
      final_report;
   end
   initial begin
      #4000;
      err_count++;
      final_report;
   end
endmodule
bind rsp_array rsp_array_properties #(.N_REG(N_REG)) chk_u (.clk_i, .nrst_i,
   .reg_oe_n_i, .preload_i, .fuse_i, .pol_high_i, .oe_fuse_i, .sec_fuse_i,
   .rd_idx_i, .pin_o, .pin_oe_o, .rd_data_o, .rd_ok_o);
